// file: ddrpi_core.sv
/*
 * device end of a ddr sdram pin interface: command decode, bank state,
 * read and write bursts with strobes and byte masks, small storage array.
 * assumes all pins arrive asynchronously to clk_i and that the link clock
 * is slow enough (8 clk_i periods or more) to be sampled and edge-found.
 */
// Functional notes
// - command/address sampled on both clock edges
// - chip select, clock enable on rising edge
// - cs, cke and bus form command code
// - cke low stops clocks, buffers, drivers
// - power state follows clock enable level
// - lowest column bit always zero
// - unused row/column positions ignored
// - eight banks, 13 row, 9 column bits
// - 32-bit data bus, bidirectional
// - burst of 4, 8 or 16 beats
// - separate programmable read, write latency
// - strobe driven with read data
// - read strobe edges aligned with data
// - one strobe per byte lane
// - masked write bytes are not stored
// - mask sampled on both strobe edges
// - mask n governs byte lane n
// - single-bank refresh leaves others usable
`timescale 1ns/1ps
`include "ddrpi_params.svh"
`default_nettype none

module ddrpi_core #(
  parameter int MEM_AW = 8  // storage address bits, bank bits included
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // command pins
  input  wire logic                       diff_clock_true_i,
  input  wire logic                       diff_clock_comp_i,
  input  wire logic                       cke_i,
  input  wire logic                       cs_n_i,
  input  wire logic [`DDRPI_CAB_W-1:0]    cmd_addr_bus_i,
  // data pins
  input  wire logic [`DDRPI_DQ_W-1:0]     dq_i,
  output logic      [`DDRPI_DQ_W-1:0]     dq_o,
  output logic                            dq_oe_n_o,
  input  wire logic [`DDRPI_LANES-1:0]    write_byte_mask_i,
  // strobe pins
  input  wire logic [`DDRPI_LANES-1:0]    dqs_t_i,
  input  wire logic [`DDRPI_LANES-1:0]    dqs_c_i,
  output logic      [`DDRPI_LANES-1:0]    dqs_t_o,
  output logic      [`DDRPI_LANES-1:0]    dqs_c_o,
  output logic                            dqs_oe_n_o,
  // status
  output logic                            clk_run_o,
  output logic      [7:0]                 bank_open_o,
  output logic                            refresh_late_o
);

  localparam int LANES = `DDRPI_LANES;
  localparam int NBANK = 1 << `DDRPI_BANK_W;

  // storage can only be indexed by bank plus low column bits
  initial begin
    if (MEM_AW < 4 || MEM_AW > `DDRPI_BANK_W + `DDRPI_COL_W - 1)
      $error("ddrpi_core: MEM_AW out of range");
  end

  // three-stage pin synchroniser; stage 1 feeds stage 2 only
  ddrpi_pkg::ddrpi_pin_t pins_w;  // raw pins as one bundle
  ddrpi_pkg::ddrpi_pin_t s1_r;    // first stage
  ddrpi_pkg::ddrpi_pin_t s2_r;    // second stage
  ddrpi_pkg::ddrpi_pin_t s3_r;    // third stage

  assign pins_w = '{ck_t: diff_clock_true_i, ck_c: diff_clock_comp_i, cke: cke_i,
                    cs_n: cs_n_i, cab: cmd_addr_bus_i, dq: dq_i,
                    msk: write_byte_mask_i, dqs_t: dqs_t_i, dqs_c: dqs_c_i};

  // no reset: pure delay line
  always_ff @(posedge clk_i) begin
    s1_r <= pins_w;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // link clock edges: a level counts once stages 2 and 3 agree
  logic ck_lvl_r;  // accepted differential clock level
  logic ck_ok_w;   // stable and differential
  logic ck_rise_w; // positive edge found this cycle
  logic ck_fall_w; // negative edge found this cycle

  assign ck_ok_w   = (s2_r.ck_t == s3_r.ck_t) && (s2_r.ck_c == s3_r.ck_c)
                     && (s3_r.ck_t != s3_r.ck_c);
  assign ck_rise_w = ck_ok_w && s3_r.ck_t && !ck_lvl_r;
  assign ck_fall_w = ck_ok_w && !s3_r.ck_t && ck_lvl_r;

  // track the accepted clock level
  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      ck_lvl_r <= 1'b0;
    else if (ck_rise_w || ck_fall_w)
      ck_lvl_r <= s3_r.ck_t;
  end

  // strobe edges per lane, same agreement scheme
  logic [LANES-1:0] dqs_lvl_r;  // accepted strobe level per lane
  logic [LANES-1:0] dqs_edge_w; // either edge of the true strobe

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      dqs_edge_w[l] = (s2_r.dqs_t[l] == s3_r.dqs_t[l])
                      && (s2_r.dqs_c[l] == s3_r.dqs_c[l])
                      && (s3_r.dqs_t[l] != s3_r.dqs_c[l])
                      && (s3_r.dqs_t[l] != dqs_lvl_r[l]);
    end
  end

  // follow each lane's strobe level
  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      dqs_lvl_r <= '0;
    else begin
      for (int l = 0; l < LANES; l++) begin
        if (dqs_edge_w[l])
          dqs_lvl_r[l] <= s3_r.dqs_t[l];
      end
    end
  end

  // rising half: cs, cke and first half of the bus; falling half: second half
  logic                    clk_run_r;  // cke seen high at last rising edge
  logic                    cmd_pend_r; // rising half of a command held
  logic [`DDRPI_CAB_W-1:0] cab_rise_r; // bus value at the rising edge
  logic                    cmd_go_w;   // full command present this cycle
  ddrpi_pkg::ddrpi_cmd_t   op_w;       // decoded opcode
  logic [`DDRPI_BANK_W-1:0] bank_w;    // bank select bits
  logic [`DDRPI_ROW_W-1:0] row_w;      // row address
  logic [`DDRPI_COL_W-1:0] col_w;      // column address

  assign cmd_go_w = ck_fall_w && cmd_pend_r && clk_run_r;
  assign op_w     = ddrpi_pkg::ddrpi_cmd_t'(cab_rise_r[`DDRPI_OP_LSB +: `DDRPI_OP_W]);
  assign bank_w   = cab_rise_r[`DDRPI_BANK_LSB +: `DDRPI_BANK_W];
  assign row_w    = {cab_rise_r[`DDRPI_ROWHI_LSB +: `DDRPI_ROWHI_W],
                     s3_r.cab[`DDRPI_ROW_W-`DDRPI_ROWHI_W-1:0]};
  // lowest column bit is implied zero; bus bits above C8 ignored
  assign col_w    = {s3_r.cab[`DDRPI_COL_W-2:0], 1'b0};

  // sample single-rate pins on the rising edge only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      clk_run_r  <= 1'b0;
      cmd_pend_r <= 1'b0;
      cab_rise_r <= '0;
    end else if (ck_rise_w) begin
      clk_run_r  <= s3_r.cke;
      cmd_pend_r <= s3_r.cke && !s3_r.cs_n;
      cab_rise_r <= s3_r.cab;
    end else if (ck_fall_w) begin
      cmd_pend_r <= 1'b0;
    end
  end

  // mode settings, written only while no burst runs
  ddrpi_pkg::ddrpi_mode_t mode_r;
  ddrpi_pkg::ddrpi_state_t state_r;
  logic [4:0] nb_w;  // beats per burst

  // unknown length codes fall back to four beats
  always_comb begin
    case (mode_r.blc)
      `DDRPI_BLC_8:  nb_w = 5'h08;
      `DDRPI_BLC_16: nb_w = 5'h10;
      default:       nb_w = 5'h04;
    endcase
  end

  // mode writes; reserved length code leaves the old setting
  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      mode_r <= '{blc: `DDRPI_BLC_RESET, rdl: `DDRPI_RDL_RESET, wrl: `DDRPI_WRL_RESET};
    else if (cmd_go_w && op_w == ddrpi_pkg::DDRPI_CMD_MODE && state_r == ddrpi_pkg::DDRPI_IDLE) begin
      if (s3_r.cab[`DDRPI_BLC_LSB +: 2] != 2'h3)
        mode_r.blc <= s3_r.cab[`DDRPI_BLC_LSB +: 2];
      mode_r.rdl <= s3_r.cab[`DDRPI_RDL_LSB +: `DDRPI_LAT_W];
      mode_r.wrl <= s3_r.cab[`DDRPI_WRL_LSB +: `DDRPI_LAT_W];
    end
  end

  // open row per bank; a bank refresh closes only its own bank
  logic [NBANK-1:0]        open_r;           // bank has an open row
  logic [`DDRPI_ROW_W-1:0] row_r [NBANK];    // open row per bank

  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      open_r <= '0;
    else if (cmd_go_w) begin
      case (op_w)
        ddrpi_pkg::DDRPI_CMD_ACT:  open_r[bank_w] <= 1'b1;
        ddrpi_pkg::DDRPI_CMD_REFA: open_r <= '0;
        ddrpi_pkg::DDRPI_CMD_REFB: open_r[bank_w] <= 1'b0;
        default:                   open_r <= open_r;
      endcase
    end
  end

  // row address memory needs no reset
  always_ff @(posedge clk_i) begin
    if (cmd_go_w && op_w == ddrpi_pkg::DDRPI_CMD_ACT)
      row_r[bank_w] <= row_w;
  end

  // storage is small: bank plus low column bits pick the word
  logic [`DDRPI_DQ_W-1:0] mem_r [1 << MEM_AW];

  function automatic logic [MEM_AW-1:0] mem_idx(input logic [`DDRPI_BANK_W-1:0] b,
                                                input logic [`DDRPI_COL_W-1:0]  c);
    mem_idx = {b, c[MEM_AW-`DDRPI_BANK_W-1:0]};
  endfunction : mem_idx

  // burst sequencer
  logic [`DDRPI_BANK_W-1:0] bk_r;       // bank of the running burst
  logic [`DDRPI_COL_W-1:0]  col_r;      // start column of the burst
  logic [`DDRPI_LAT_W-1:0]  lat_r;      // rising edges still to wait
  logic [4:0]               rbeat_r;    // read beats driven
  logic [4:0]               wbeat_r [LANES]; // write beats taken per lane
  logic                     wdone_w;    // every lane has its full burst
  logic                     rd_ok_w;    // read to an open bank
  logic                     wr_ok_w;    // write to an open bank

  assign rd_ok_w = cmd_go_w && op_w == ddrpi_pkg::DDRPI_CMD_RD && open_r[bank_w];
  assign wr_ok_w = cmd_go_w && op_w == ddrpi_pkg::DDRPI_CMD_WR && open_r[bank_w];

  always_comb begin
    wdone_w = 1'b1;
    for (int l = 0; l < LANES; l++)
      wdone_w = wdone_w && (wbeat_r[l] == nb_w);
  end

  // state and latency; cke low aborts any burst and drops the drivers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ddrpi_pkg::DDRPI_IDLE;
      lat_r   <= '0;
      bk_r    <= '0;
      col_r   <= '0;
    end else if (ck_rise_w && !s3_r.cke) begin
      state_r <= ddrpi_pkg::DDRPI_IDLE;
    end else begin
      case (state_r)
        ddrpi_pkg::DDRPI_IDLE: begin
          if (rd_ok_w || wr_ok_w) begin
            bk_r    <= bank_w;
            col_r   <= col_w;
            lat_r   <= rd_ok_w ? mode_r.rdl : mode_r.wrl;
            state_r <= rd_ok_w ? ddrpi_pkg::DDRPI_RLAT : ddrpi_pkg::DDRPI_WLAT;
          end
        end
        ddrpi_pkg::DDRPI_WLAT: begin
          if (ck_rise_w) begin
            lat_r <= lat_r - 4'h1;
            if (lat_r <= 4'h1)
              state_r <= ddrpi_pkg::DDRPI_WDATA;
          end
        end
        ddrpi_pkg::DDRPI_WDATA: begin
          if (wdone_w)
            state_r <= ddrpi_pkg::DDRPI_IDLE;
        end
        ddrpi_pkg::DDRPI_RLAT: begin
          if (ck_rise_w) begin
            lat_r <= lat_r - 4'h1;
            if (lat_r <= 4'h1)
              state_r <= ddrpi_pkg::DDRPI_RDATA;
          end
        end
        ddrpi_pkg::DDRPI_RDATA: begin
          if ((ck_rise_w || ck_fall_w) && rbeat_r == nb_w)
            state_r <= ddrpi_pkg::DDRPI_IDLE;
        end
        default: state_r <= ddrpi_pkg::DDRPI_IDLE;
      endcase
    end
  end

  // write capture: each lane steps on both strobe edges, mask per byte
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state_r != ddrpi_pkg::DDRPI_WDATA) begin
      for (int l = 0; l < LANES; l++)
        wbeat_r[l] <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (dqs_edge_w[l] && wbeat_r[l] != nb_w)
          wbeat_r[l] <= wbeat_r[l] + 5'h01;
      end
    end
  end

  // store only unmasked bytes; column counts up by one per beat from the burst start column
  always_ff @(posedge clk_i) begin
    if (state_r == ddrpi_pkg::DDRPI_WDATA) begin
      for (int l = 0; l < LANES; l++) begin
        if (dqs_edge_w[l] && wbeat_r[l] != nb_w && !s3_r.msk[l])
          mem_r[mem_idx(bk_r, col_r + `DDRPI_COL_W'(wbeat_r[l]))][l*8 +: 8]
            <= s3_r.dq[l*8 +: 8];
      end
    end
  end

  // read drive: data and strobe change together on each link edge
  logic [`DDRPI_DQ_W-1:0]  dq_r;    // read data on the pins
  logic                    oe_n_r;  // low while the device drives
  logic                    dqs_r;   // common strobe level, all lanes
  logic                    dqsc_r;  // complement strobe, low when released

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dq_r    <= '0;
      dqsc_r  <= 1'b0;
      oe_n_r  <= 1'b1;
      dqs_r   <= 1'b0;
      rbeat_r <= '0;
    end else if (state_r != ddrpi_pkg::DDRPI_RDATA || (ck_rise_w && !s3_r.cke)) begin
      oe_n_r  <= 1'b1;
      dqsc_r  <= 1'b0;
      dqs_r   <= 1'b0;
      rbeat_r <= '0;
      // first beat leaves on the edge that ends the read latency
      if (state_r == ddrpi_pkg::DDRPI_RLAT && ck_rise_w && lat_r <= 4'h1 && s3_r.cke) begin
        dq_r    <= mem_r[mem_idx(bk_r, col_r)];
        dqs_r   <= 1'b1;
        oe_n_r  <= 1'b0;
        rbeat_r <= 5'h01;
      end
    end else if (ck_rise_w || ck_fall_w) begin
      if (rbeat_r == nb_w) begin
        oe_n_r <= 1'b1;
        dqs_r  <= 1'b0;
        dqsc_r <= 1'b0;
      end else begin
        dq_r    <= mem_r[mem_idx(bk_r, col_r + `DDRPI_COL_W'(rbeat_r))];
        dqs_r   <= !dqs_r;
        dqsc_r  <= dqs_r;
        rbeat_r <= rbeat_r + 5'h01;
      end
    end
  end

  // refresh watchdog: flags a gap longer than the all-bank interval
  localparam logic [11:0] REFI_CYC = 12'(`DDRPI_REFI_CYC);
  logic [11:0] refi_cnt_r;  // cycles since last all-bank refresh
  logic        late_r;      // interval exceeded

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      refi_cnt_r <= '0;
      late_r     <= 1'b0;
    end else if (cmd_go_w && op_w == ddrpi_pkg::DDRPI_CMD_REFA) begin
      refi_cnt_r <= '0;
      late_r     <= 1'b0;
    end else if (refi_cnt_r == REFI_CYC) begin
      late_r <= 1'b1; // counter parks at the limit
    end else begin
      refi_cnt_r <= refi_cnt_r + 12'h001;
    end
  end

  // outputs straight from flip-flops
  logic [7:0] bank_open_r;  // registered copy for the status pins

  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      bank_open_r <= '0;
    else
      bank_open_r <= 8'(open_r);
  end

  assign dq_o           = dq_r;
  assign dq_oe_n_o      = oe_n_r;
  assign dqs_t_o        = {LANES{dqs_r}};
  assign dqs_c_o        = {LANES{dqsc_r}};
  assign dqs_oe_n_o     = oe_n_r;
  assign clk_run_o      = clk_run_r;
  assign bank_open_o    = bank_open_r;
  assign refresh_late_o = late_r;

endmodule : ddrpi_core

`default_nettype wire

// file: ddrpi_params.svh
/*
 * constants of the ddr pin interface: field positions, encodings,
 * reset values and timing counts.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef DDRPI_PARAMS_SVH
`define DDRPI_PARAMS_SVH

// organisation
`define DDRPI_BANK_W        3
`define DDRPI_ROW_W         13
`define DDRPI_COL_W         9
`define DDRPI_DQ_W          32
`define DDRPI_LANES         4
`define DDRPI_CAB_W         10

// opcode positions in the rising-edge half of the command
`define DDRPI_OP_LSB        0
`define DDRPI_OP_W          3
`define DDRPI_BANK_LSB      3
`define DDRPI_ROWHI_LSB     6
`define DDRPI_ROWHI_W       4

// mode field positions in the falling-edge half
`define DDRPI_BLC_LSB       0
`define DDRPI_RDL_LSB       2
`define DDRPI_WRL_LSB       6
`define DDRPI_LAT_W         4

// burst length codes
`define DDRPI_BLC_4         2'h0
`define DDRPI_BLC_8         2'h1
`define DDRPI_BLC_16        2'h2

// reset values of the mode settings
`define DDRPI_BLC_RESET     2'h0
`define DDRPI_RDL_RESET     4'h3
`define DDRPI_WRL_RESET     4'h1

// refresh interval in ns and the clock period in ns
`define DDRPI_REFI_NS       7800
`define DDRPI_CLK_NS        4
`define DDRPI_REFI_CYC      (`DDRPI_REFI_NS / `DDRPI_CLK_NS)

`endif

// file: ddrpi_pkg.sv
/*
 * types of the ddr pin interface: command codes, burst states,
 * the bundle of sampled pins and the mode settings.
 * assumes ddrpi_params.svh is on the include path.
 */
`include "ddrpi_params.svh"

package ddrpi_pkg;

  // command opcodes carried in the rising-edge half
  typedef enum logic [2:0] {
    DDRPI_CMD_NOP   = 3'h0,
    DDRPI_CMD_ACT   = 3'h1,
    DDRPI_CMD_WR    = 3'h2,
    DDRPI_CMD_RD    = 3'h3,
    DDRPI_CMD_REFA  = 3'h4,
    DDRPI_CMD_REFB  = 3'h5,
    DDRPI_CMD_MODE  = 3'h6
  } ddrpi_cmd_t;

  // burst sequencer, gray along idle-latency-data
  typedef enum logic [2:0] {
    DDRPI_IDLE  = 3'h0,
    DDRPI_WLAT  = 3'h1,
    DDRPI_WDATA = 3'h3,
    DDRPI_RLAT  = 3'h4,
    DDRPI_RDATA = 3'h6
  } ddrpi_state_t;

  // all pins that enter from the link
  typedef struct packed {
    logic                      ck_t;
    logic                      ck_c;
    logic                      cke;
    logic                      cs_n;
    logic [`DDRPI_CAB_W-1:0]   cab;
    logic [`DDRPI_DQ_W-1:0]    dq;
    logic [`DDRPI_LANES-1:0]   msk;
    logic [`DDRPI_LANES-1:0]   dqs_t;
    logic [`DDRPI_LANES-1:0]   dqs_c;
  } ddrpi_pin_t;

  // programmable burst and latency settings
  typedef struct packed {
    logic [1:0]                blc;
    logic [`DDRPI_LAT_W-1:0]   rdl;
    logic [`DDRPI_LAT_W-1:0]   wrl;
  } ddrpi_mode_t;

endpackage : ddrpi_pkg

// file: ddrpi_checker.sv
/*
 * pin checker of the ddr pin interface device end.
 * assumes one clk_i domain and binding onto every ddrpi_core instance.
 */
`timescale 1ns/1ps
`include "ddrpi_params.svh"
`default_nettype none

module ddrpi_checker (
  // clock and reset
  input wire logic                     clk_i,
  input wire logic                     reset_n_i,
  // watched pins
  input wire logic                     cke_i,
  input wire logic [`DDRPI_DQ_W-1:0]   dq_o,
  input wire logic                     dq_oe_n_o,
  input wire logic [`DDRPI_LANES-1:0]  dqs_t_o,
  input wire logic [`DDRPI_LANES-1:0]  dqs_c_o,
  input wire logic                     dqs_oe_n_o,
  input wire logic                     clk_run_o,
  input wire logic [7:0]               bank_open_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic [4:0] beats_r;  // strobe toggles of the running read burst

  // beat count, cleared while strobes are released
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || dqs_oe_n_o) beats_r <= 5'h0;
    else if ($changed(dqs_t_o)) beats_r <= beats_r + 5'h1;
  end

  property p_rst; $rose(reset_n_i) |-> dq_oe_n_o && dqs_oe_n_o && bank_open_o == 8'h0; endproperty
  a_rst: assert property (p_rst) else $error("drivers not off after reset");
  property p_pair; dq_oe_n_o == dqs_oe_n_o; endproperty
  a_pair: assert property (p_pair) else $error("strobe and data drivers differ");
  property p_comp; !dqs_oe_n_o |-> dqs_c_o == ~dqs_t_o; endproperty
  a_comp: assert property (p_comp) else $error("strobe pair not complementary");
  property p_idle; dqs_oe_n_o |-> dqs_t_o == 4'h0 && dqs_c_o == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("strobe moves while released");
  property p_lanes; dqs_t_o == 4'h0 || dqs_t_o == 4'hf; endproperty
  a_lanes: assert property (p_lanes) else $error("lane strobes disagree");
  property p_edge; !dq_oe_n_o && $changed(dq_o) |-> $changed(dqs_t_o); endproperty
  a_edge: assert property (p_edge) else $error("read data moved without strobe edge");
  property p_beats; $rose(dqs_oe_n_o) && clk_run_o |-> beats_r inside {5'h4, 5'h8, 5'h10}; endproperty
  a_beats: assert property (p_beats) else $error("read burst beat count wrong");
  property p_hold; $fell(dq_oe_n_o) |-> (!dq_oe_n_o) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("read burst cut short");
  property p_run; $changed(clk_run_o) |-> $past(cke_i, 2) == clk_run_o && $past(cke_i, 4) == clk_run_o; endproperty
  a_run: assert property (p_run) else $error("run state not from clock enable");
  property p_off; $fell(clk_run_o) |-> ##[0:2] (dq_oe_n_o && dqs_oe_n_o); endproperty
  a_off: assert property (p_off) else $error("drivers on with clock stopped");
endmodule : ddrpi_checker

bind ddrpi_core ddrpi_checker u_ddrpi_checker (.clk_i, .reset_n_i, .cke_i, .dq_o, .dq_oe_n_o,
  .dqs_t_o, .dqs_c_o, .dqs_oe_n_o, .clk_run_o, .bank_open_o);

`default_nettype wire

// file: ddrpi_host_model.sv
/*
 * behavioural memory controller: free link clock, command halves,
 * write bursts with centred strobes and per-beat masks.
 * assumes the bench resolves the shared data and strobe wires.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrpi_host_model (
  // link clock and command pins
  output logic        ck_t_o,
  output logic        ck_c_o,
  output logic        cke_o,
  output logic        cs_n_o,
  output logic [9:0]  cab_o,
  // write side
  output logic [31:0] dq_o,
  output logic [3:0]  msk_o,
  output logic [3:0]  dqs_t_o,
  output logic [3:0]  dqs_c_o
);
  realtime cmd_t;  // pin time of the last rising half

  // link clock, phase unrelated to clk_i
  initial begin
    ck_t_o = 1'b0;
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    cab_o = 10'h0;
    dq_o = 32'h0;
    msk_o = 4'h0;
    dqs_t_o = 4'hf;
    #5.3;
    forever #16 ck_t_o = ~ck_t_o;
  end
  assign ck_c_o = ~ck_t_o;
  assign dqs_c_o = ~dqs_t_o;

  // one command, each half centred on its edge
  task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic sel_n);
    @(negedge ck_t_o);
    #8;
    cs_n_o = sel_n;
    cab_o = r;
    @(posedge ck_t_o);
    cmd_t = $realtime;
    #8;
    cab_o = f;
    @(negedge ck_t_o);
    #8;
    cs_n_o = 1'b1;
    cab_o = ~f;  // deselected bus keeps moving
  endtask : cmd

  // clock enable changes well clear of a rising edge
  task automatic set_cke(input logic v);
    @(negedge ck_t_o);
    #8;
    cke_o = v;
  endtask : set_cke

  // waits wl rising edges, then one beat per strobe edge
  task automatic wdata(input logic [31:0] d[16], input logic [3:0] m[16], input int n,
                       input int wrl);
    dqs_t_o = 4'h0;  // preamble level
    repeat (wrl) @(posedge ck_t_o);
    for (int k = 0; k < n; k++) begin
      #8;
      dq_o = d[k];
      msk_o = m[k];
      #8;
      dqs_t_o = ~dqs_t_o;
    end
    #8;
    dq_o = ~dq_o;
    dqs_t_o = ~dqs_t_o;
  endtask : wdata
endmodule : ddrpi_host_model

`default_nettype wire

// file: ddrpi_tb.sv
/*
 * self-checking bench of the ddr pin interface device end.
 * assumes ddrpi_core, its checker and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int MAW   = 8;      // storage address bits
  localparam int LIMIT = 20000;  // cycle ceiling of the run
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  wire logic   ck_t, ck_c, cke, cs_n;
  wire logic [9:0]  cab;
  wire logic [31:0] h_dq;
  wire logic [3:0]  msk, h_dqs, h_dqc;
  logic [31:0] dq_o;
  logic [3:0]  dqs_t_o, dqs_c_o;
  logic        dq_oe_n_o, dqs_oe_n_o, clk_run_o, refresh_late_o;
  logic [7:0]  bank_open_o;
  logic [31:0] mem [int];      // expected storage
  logic [31:0] rd_q [$];       // captured read beats
  logic [3:0]  prev_t = 4'h0;  // strobe of the previous cycle
  logic [2:0]  b3;
  logic [7:0]  hc;
  realtime     first_t;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          nb, rdl, wrl;

  always #2 clk_i = ~clk_i;

  ddrpi_host_model host (.ck_t_o(ck_t), .ck_c_o(ck_c), .cke_o(cke), .cs_n_o(cs_n), .cab_o(cab),
    .dq_o(h_dq), .msk_o(msk), .dqs_t_o(h_dqs), .dqs_c_o(h_dqc));
  // shared wires: whoever enables wins
  ddrpi_core #(.MEM_AW(MAW)) u_ddrpi_core (.clk_i, .reset_n_i, .diff_clock_true_i(ck_t),
    .diff_clock_comp_i(ck_c), .cke_i(cke), .cs_n_i(cs_n), .cmd_addr_bus_i(cab),
    .dq_i(dq_oe_n_o ? h_dq : dq_o), .dq_o, .dq_oe_n_o, .write_byte_mask_i(msk),
    .dqs_t_i(dqs_oe_n_o ? h_dqs : dqs_t_o), .dqs_c_i(dqs_oe_n_o ? h_dqc : dqs_c_o),
    .dqs_t_o, .dqs_c_o, .dqs_oe_n_o, .clk_run_o, .bank_open_o, .refresh_late_o);

  // read beat capture on every driven strobe change
  always @(posedge clk_i) begin
    prev_t <= dqs_t_o;
    if (!dqs_oe_n_o && dqs_t_o !== prev_t) begin
      if (rd_q.size() == 0) first_t = $realtime;
      rd_q.push_back(dq_o);
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  // rising half with junk in the unused row bits
  function automatic logic [9:0] rise(input ddrpi_pkg::ddrpi_cmd_t o, input logic [2:0] b);
    return {4'($urandom), b, o};
  endfunction : rise

  function automatic int key(input logic [2:0] b, input logic [8:0] c);
    return int'(b) * (2 ** (MAW - 3)) + int'(c) % (2 ** (MAW - 3));
  endfunction : key

  // masked lanes keep the old byte
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] m);
    for (int l = 0; l < 4; l++) begin
      if (m[l]) d[8*l +: 8] = o[8*l +: 8];
    end
    return d;
  endfunction : merge

  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t ns: %s", $realtime, what);
    end
  endtask : check

  task automatic op(input ddrpi_pkg::ddrpi_cmd_t o, input logic [2:0] b);
    host.cmd(rise(o, b), 10'($urandom), 1'b0);
    repeat (8) @(posedge clk_i);
  endtask : op

  task automatic mode(input logic [1:0] c, input int r, input int w);
    host.cmd(rise(ddrpi_pkg::DDRPI_CMD_MODE, 3'h0), {4'(w), 4'(r), c}, 1'b0);
    nb = 4 << c;
    rdl = r;
    wrl = w;
    repeat (8) @(posedge clk_i);
  endtask : mode

  // write burst; a deselected one leaves the model alone
  task automatic wr(input logic [2:0] b, input logic [7:0] c, input logic mk, input logic seln);
    logic [31:0] d [16];
    logic [3:0]  m [16];
    int          k;
    for (int i = 0; i < nb; i++) begin
      d[i] = $urandom;
      m[i] = mk ? 4'($urandom) : 4'h0;
      k = key(b, {c, 1'b0} + 9'(i));
      if (!seln) mem[k] = mk ? merge(mem[k], d[i], m[i]) : d[i];
    end
    host.cmd(rise(ddrpi_pkg::DDRPI_CMD_WR, b), {2'($urandom), c}, seln);
    host.wdata(d, m, nb, wrl);
    repeat (8) @(posedge clk_i);
  endtask : wr

  // read burst expecting n beats
  task automatic rd(input logic [2:0] b, input logic [7:0] c, input int n, input logic seln);
    int w;
    int k;
    rd_q.delete();
    host.cmd(rise(ddrpi_pkg::DDRPI_CMD_RD, b), {2'($urandom), c}, seln);
    w = 0;
    while (rd_q.size() < n && w < 600) begin
      @(posedge clk_i);
      w++;
    end
    repeat (60) @(posedge clk_i);
    check(rd_q.size() == n, "read beat count");
    if (n > 0) check(first_t - host.cmd_t >= rdl * 32 + 4 && first_t - host.cmd_t <= rdl * 32 + 36,
                     "read latency");
    for (int i = 0; i < rd_q.size(); i++) begin
      k = key(b, {c, 1'b0} + 9'(i));
      if (mem.exists(k)) check(rd_q[i] === mem[k], "read data");
    end
  endtask : rd

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    void'($urandom(32'h407b));
    nb = 4;
    rdl = 3;
    wrl = 1;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    check(dq_oe_n_o === 1'b1 && dqs_oe_n_o === 1'b1, "drivers off in reset");
    repeat (20) @(posedge clk_i);
    check(clk_run_o === 1'b1, "clock running");
    rd(3'h2, 8'h10, 0, 1'b0);
    done("reset");
    for (int b = 0; b < 8; b++) begin
      op(ddrpi_pkg::DDRPI_CMD_ACT, 3'(b));
      check(bank_open_o[b] === 1'b1, "bank open");
    end
    done("activate");
    for (int c = 2; c >= 0; c--) begin
      b3 = 3'($urandom);
      hc = (c == 0) ? 8'hff : 8'($urandom);
      mode(2'(c), 2 + $urandom % 5, 1 + $urandom % 3);
      wr(b3, hc, 1'b0, 1'b0);
      wr(b3, hc, 1'b1, 1'b0);
      rd(b3, hc, nb, 1'b0);
      rd(b3, hc + 8'h1, nb, 1'b0);
    end
    done("bursts");
    wr(b3, hc, 1'b0, 1'b1);
    rd(b3, hc, 0, 1'b1);
    rd(b3, hc, nb, 1'b0);
    done("deselect");
    host.set_cke(1'b0);
    repeat (20) @(posedge clk_i);
    check(clk_run_o === 1'b0, "clock stopped");
    rd(b3, hc, 0, 1'b0);
    host.set_cke(1'b1);
    repeat (20) @(posedge clk_i);
    check(clk_run_o === 1'b1, "clock restarted");
    rd(b3, hc, nb, 1'b0);
    done("clock enable");
    op(ddrpi_pkg::DDRPI_CMD_REFB, b3 + 3'h1);
    check(bank_open_o[b3] === 1'b1, "other bank open");
    check(bank_open_o[b3 + 3'h1] === 1'b0, "refreshed bank closed");
    rd(b3, hc, nb, 1'b0);
    // run is far past the interval by now, so the flag must stand
    check(refresh_late_o === 1'b1, "refresh overdue");
    op(ddrpi_pkg::DDRPI_CMD_REFA, 3'h0);
    check(refresh_late_o === 1'b0, "refresh flag");
    done("refresh");
    give_verdict();
  end
endmodule : tb

`default_nettype wire
